/* hw/oad_pkg.sv */
// shared constants and types for the operand addressing decoder
package oad_pkg;
  localparam int ADDR_W = 12;
  localparam int FR_W = 9;
  localparam int OFS_W = 7;
  localparam int INSN_W = 16;
  localparam int PTR_W = 16;
  localparam int NPTR = 3;
  localparam int PI_IP = 0;
  localparam int PI_DP = 1;
  localparam int PI_SP = 2;
  // instruction field positions
  localparam int CLS_HI = 15;
  localparam int CLS_LO = 14;
  localparam int SUB_BIT = 13;
  localparam int OP2_HI = 13;
  localparam int OP2_LO = 10;
  localparam int DSEL_BIT = 9;
  localparam int BOP_HI = 13;
  localparam int BOP_LO = 12;
  localparam int BSEL_HI = 11;
  localparam int BSEL_LO = 9;
  localparam int IOP_HI = 12;
  localparam int IOP_LO = 8;
  localparam int LIT_HI = 7;
  localparam int JADR_HI = 12;
  localparam int PAGE_HI = 2;
  // instruction classes
  localparam logic [1:0] CLS_TWO = 2'h0;
  localparam logic [1:0] CLS_IMM = 2'h1;
  localparam logic [1:0] CLS_BIT = 2'h2;
  localparam logic [1:0] CLS_JMP = 2'h3;
  // two-operand opcodes
  localparam logic [3:0] OP_CLRCMP = 4'hD;
  localparam logic [3:0] OP_STACK = 4'hE;
  localparam logic [3:0] OP_MUL = 4'hF;
  // immediate and misc opcodes
  localparam logic [4:0] IOP_SPR = 5'h1C;
  localparam logic [4:0] IOP_PUSHL = 5'h1D;
  localparam logic [4:0] IOP_LOADH = 5'h1E;
  localparam logic [4:0] IOP_LOADL = 5'h1F;
  localparam logic [4:0] MOP_PAGE = 5'h01;
  // data space
  localparam logic [11:0] GLB_BASE = 12'h080;
  localparam logic [11:0] A_PTR_BASE = 12'h004;
  localparam logic [15:0] PTR_RST = 16'h0000;
  // wishbone byte addresses
  localparam int WORD_B = 4;
  localparam logic [7:0] R_PTR_BASE = 8'h00;
  localparam logic [7:0] R_PAGE = 8'h18;
  localparam logic [7:0] R_PRODH = 8'h1C;
  localparam logic [7:0] R_EA = 8'h20;
  typedef enum logic [4:0] {
    M_IND = 5'h01, M_SPR = 5'h02, M_GLB = 5'h04, M_DPO = 5'h08, M_SPO = 5'h10
  } oad_mode_t;
  typedef enum logic [4:0] {
    F_TWO = 5'h01, F_IMM = 5'h02, F_JMP = 5'h04, F_BIT = 5'h08, F_MISC = 5'h10
  } oad_fmt_t;
endpackage

/* hw/oad_ea_unit.sv */
// effective address unit for the operand location field
module oad_ea_unit (
  // operand location field
  input wire logic [oad_pkg::FR_W-1:0] operand_location_field_i,
  // pointer pairs
  input wire logic [oad_pkg::PTR_W-1:0] ind_ptr_i,
  input wire logic [oad_pkg::PTR_W-1:0] data_ptr_i,
  input wire logic [oad_pkg::PTR_W-1:0] stack_ptr_i,
  // result
  output logic [oad_pkg::ADDR_W-1:0] ea_o,
  output oad_pkg::oad_mode_t mode_o
);
  localparam int AW = oad_pkg::ADDR_W;
  logic [AW-1:0] base;
  logic [AW-1:0] ofs;
  logic [1:0] top;
  assign ofs = AW'(operand_location_field_i[oad_pkg::OFS_W-1:0]);
  assign top = operand_location_field_i[oad_pkg::FR_W-1:oad_pkg::FR_W-2];
  // [RULE6] base pointer pick
  assign base = top[0] ? stack_ptr_i[AW-1:0] : data_ptr_i[AW-1:0];
  always_comb begin
    ea_o = ofs;
    mode_o = oad_pkg::M_SPR;
    if (operand_location_field_i == '0) begin
      // [RULE1] all zero means indirect
      mode_o = oad_pkg::M_IND;
      // [RULE2] upper nibble dropped
      ea_o = ind_ptr_i[AW-1:0];
    end else if (top[1]) begin
      // [RULE4] offset mode select
      mode_o = top[0] ? oad_pkg::M_SPO : oad_pkg::M_DPO;
      // [RULE5] base plus offset
      // [RULE23] wraps in data space
      ea_o = AW'(base + ofs);
    end else if (top[0]) begin
      // [RULE21] global register window
      mode_o = oad_pkg::M_GLB;
      ea_o = AW'(oad_pkg::GLB_BASE + ofs);
    end
  end
endmodule // oad_ea_unit

/* hw/oad_decoder.sv */
// operand addressing decoder with wishbone register access
//
// Contract
// [RULE1] operand location field all zero selects register-indirect mode
// [RULE2] indirect address is low 12 bits of pointer; top nibble unused
// [RULE3] software avoids pointer modes for addresses 0x000 to 0x01F
// [RULE4] operand field bit 8 set selects pointer-plus-offset mode
// [RULE5] offset address is 12-bit base plus 7-bit unsigned offset
// [RULE6] field bit 7 picks data pointer (0) or stack pointer (1)
// [RULE7] high-load and low-load instructions write data pointer bytes
// [RULE8] push and pop move a byte and adjust stack pointer
// [RULE9] data stack grows toward lower addresses
// [RULE10] data stack is separate from call return stack
// [RULE11] one 16-bit word per instruction, one per clock
// [RULE12] select bit routes two-operand result to accumulator or location
// [RULE13] multiply ignores select; high byte to product reg, low to acc
// [RULE14] single-operand select: zero writes accumulator, one writes location
// [RULE15] select bit extends opcode for clear/compare type pairs
// [RULE16] immediate carries 8-bit literal to accumulator, stack or special
// [RULE17] jump target is page bits above 13 encoded bits
// [RULE18] three-bit field picks one bit of the addressed register
// [RULE19] five instruction formats are recognised
// [RULE20] operand field is 9 bits holding mode and address or offset
// [RULE21] field 00 gives special register, 01 gives 0x080 plus low bits
// [RULE22] pointer low byte carry increments high, borrow decrements high
// [RULE23] base plus offset is truncated to 12 bits
// [RULE24] push decrements before store, pop increments after load
module oad_decoder #(
  parameter int WB_AW = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // fetched instruction
  input wire logic insn_valid_i,
  input wire logic [oad_pkg::INSN_W-1:0] insn_i,
  // core write-back into data space
  input wire logic wr_valid_i,
  input wire logic [oad_pkg::ADDR_W-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_carry_i,
  input wire logic wr_borrow_i,
  // multiplier result
  input wire logic prod_valid_i,
  input wire logic [15:0] prod_i,
  // decoded operation
  output logic dec_valid_o,
  output logic [4:0] fmt_o,
  output logic [4:0] mode_o,
  output logic [oad_pkg::ADDR_W-1:0] ea_o,
  output logic [4:0] op_o,
  output logic src_mem_o,
  output logic dst_mem_o,
  output logic dst_acc_o,
  output logic dst_prodh_o,
  output logic dst_spr_o,
  output logic stk_rd_o,
  output logic stk_wr_o,
  output logic [oad_pkg::ADDR_W-1:0] stk_addr_o,
  output logic [7:0] literal_o,
  output logic jump_o,
  output logic call_o,
  output logic [15:0] target_o,
  output logic [1:0] bit_op_o,
  output logic [7:0] bit_mask_o,
  // product high byte
  output logic [7:0] product_high_register_o
);
  localparam int AW = oad_pkg::ADDR_W;
  localparam int SP = oad_pkg::PI_SP;
  localparam int DP = oad_pkg::PI_DP;

  function automatic logic [WB_AW-1:0] reg_adr(input int k, input int h);
    return WB_AW'(oad_pkg::R_PTR_BASE + (2 * k + h) * oad_pkg::WORD_B);
  endfunction

  function automatic logic [AW-1:0] core_adr(input int k, input int h);
    return AW'(oad_pkg::A_PTR_BASE + 2 * k + h);
  endfunction

  function automatic logic [15:0] ptr_write(input logic [15:0] p,
      input logic lo, input logic [7:0] d, input logic cy, input logic bw);
    logic [7:0] hi;
    hi = p[15:8];
    if (!lo) begin
      return {d, p[7:0]};
    end
    if (cy) begin
      hi = hi + 8'h01;
    end else if (bw) begin
      hi = hi - 8'h01;
    end
    return {hi, d};
  endfunction

  logic [oad_pkg::PTR_W-1:0] ptr [oad_pkg::NPTR];
  logic [2:0] page_select_bits;
  logic [oad_pkg::FR_W-1:0] operand_location_field;
  logic [AW-1:0] ea_now;
  oad_pkg::oad_mode_t mode_now;
  logic [1:0] cls;
  logic [3:0] op2;
  logic [4:0] iop;
  logic dsel;
  logic is_two, is_imm, is_misc, is_jmp;
  logic is_mul, is_stk, is_cc, is_push, is_pop;
  logic is_pushl, is_ldh, is_ldl, is_spr, is_page;
  logic [15:0] sp_dec, sp_inc;
  logic wb_wr;
  logic [31:0] next_rdat;
  logic [AW-1:0] ofs_base;

  default clocking ast_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // [RULE20] nine-bit operand field
  assign operand_location_field = insn_i[oad_pkg::FR_W-1:0];
  assign cls = insn_i[oad_pkg::CLS_HI:oad_pkg::CLS_LO];
  assign op2 = insn_i[oad_pkg::OP2_HI:oad_pkg::OP2_LO];
  assign iop = insn_i[oad_pkg::IOP_HI:oad_pkg::IOP_LO];
  assign dsel = insn_i[oad_pkg::DSEL_BIT];
  assign is_two = cls == oad_pkg::CLS_TWO;
  assign is_imm = cls == oad_pkg::CLS_IMM && !insn_i[oad_pkg::SUB_BIT];
  assign is_misc = cls == oad_pkg::CLS_IMM && insn_i[oad_pkg::SUB_BIT];
  assign is_jmp = cls == oad_pkg::CLS_JMP;
  assign is_mul = is_two && op2 == oad_pkg::OP_MUL;
  assign is_stk = is_two && op2 == oad_pkg::OP_STACK;
  assign is_cc = is_two && op2 == oad_pkg::OP_CLRCMP;
  assign is_push = is_stk && !dsel;
  assign is_pop = is_stk && dsel;
  assign is_pushl = is_imm && iop == oad_pkg::IOP_PUSHL;
  assign is_ldh = is_imm && iop == oad_pkg::IOP_LOADH;
  assign is_ldl = is_imm && iop == oad_pkg::IOP_LOADL;
  assign is_spr = is_imm && iop == oad_pkg::IOP_SPR;
  assign is_page = is_misc && iop == oad_pkg::MOP_PAGE;
  // [RULE9] stack grows downward
  assign sp_dec = ptr[SP] - 16'h0001;
  assign sp_inc = ptr[SP] + 16'h0001;
  assign ofs_base = insn_i[oad_pkg::FR_W-2] ? ptr[SP][AW-1:0] : ptr[DP][AW-1:0];

  oad_ea_unit u_ea (
    .operand_location_field_i(operand_location_field),
    .ind_ptr_i(ptr[oad_pkg::PI_IP]),
    .data_ptr_i(ptr[DP]),
    .stack_ptr_i(ptr[SP]),
    .ea_o(ea_now),
    .mode_o(mode_now)
  );

  // write takes effect on the edge that sees ack high
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

  // pointer pairs; instruction effects win over core and bus writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < oad_pkg::NPTR; k++) begin
        ptr[k] <= oad_pkg::PTR_RST;
      end
    end else begin
      for (int k = 0; k < oad_pkg::NPTR; k++) begin
        for (int h = 0; h < 2; h++) begin
          if (wb_wr && wb_adr_i == reg_adr(k, h)) begin
            ptr[k] <= ptr_write(ptr[k], h != 0, wb_dat_i[7:0], 1'b0, 1'b0);
          end
          // [RULE22] carry ripples to high
          if (wr_valid_i && wr_addr_i == core_adr(k, h)) begin
            ptr[k] <= ptr_write(ptr[k], h != 0, wr_data_i, wr_carry_i,
                                wr_borrow_i);
          end
        end
      end
      if (insn_valid_i) begin
        // [RULE7] literal loads data pointer
        if (is_ldh) begin
          ptr[DP][15:8] <= insn_i[oad_pkg::LIT_HI:0];
        end
        if (is_ldl) begin
          ptr[DP][7:0] <= insn_i[oad_pkg::LIT_HI:0];
        end
        // [RULE24] pre-decrement, post-increment
        if (is_push || is_pushl) begin
          ptr[SP] <= sp_dec;
        end
        if (is_pop) begin
          ptr[SP] <= sp_inc;
        end
      end
    end
  end

  // [RULE22] carry reaches high byte
  AST_PTR_CARRY: assert property (  // [RULE22]
    wr_valid_i && wr_carry_i && !insn_valid_i && wr_addr_i == core_adr(DP, 1)
    |=> ptr[DP][15:8] == 8'($past(ptr[DP][15:8]) + 8'h01)
        && ptr[DP][7:0] == $past(wr_data_i))
    else $error("pointer carry did not reach high byte");

  // [RULE7] load high byte
  AST_LOAD_DP: assert property (  // [RULE7]
    insn_valid_i && is_ldh |=> ptr[DP][15:8] == $past(insn_i[7:0]))
    else $error("high-load did not write data pointer");

  // [RULE10] calls leave data stack
  AST_CALL_SP: assert property (  // [RULE10]
    insn_valid_i && is_jmp && !wr_valid_i && !wb_wr |=> $stable(ptr[SP]))
    else $error("jump or call changed stack pointer");

  // page bits, loaded by page instruction or bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_select_bits <= '0;
    end else if (insn_valid_i && is_page) begin
      page_select_bits <= insn_i[oad_pkg::PAGE_HI:0];
    end else if (wb_wr && wb_adr_i == WB_AW'(oad_pkg::R_PAGE)) begin
      page_select_bits <= wb_dat_i[oad_pkg::PAGE_HI:0];
    end
  end

  // [RULE13] upper product byte kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      product_high_register_o <= '0;
    end else if (prod_valid_i) begin
      product_high_register_o <= prod_i[15:8];
    end
  end

  // decode stage, one word per clock with no stall
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_valid_o <= 1'b0;
      fmt_o <= '0;
      mode_o <= '0;
      ea_o <= '0;
      op_o <= '0;
      stk_addr_o <= '0;
      literal_o <= '0;
      target_o <= '0;
      bit_op_o <= '0;
      bit_mask_o <= '0;
    end else begin
      // [RULE11] single-cycle throughput
      dec_valid_o <= insn_valid_i;
      if (insn_valid_i) begin
        mode_o <= mode_now;
        ea_o <= ea_now;
        op_o <= {1'b0, op2};
        // [RULE19] five formats
        unique case (cls)
          oad_pkg::CLS_TWO: begin
            fmt_o <= oad_pkg::F_TWO;
            // [RULE15] select extends opcode
            op_o <= {op2, (is_cc || is_stk) ? dsel : 1'b0};
            stk_addr_o <= dsel ? ptr[SP][AW-1:0] : sp_dec[AW-1:0];
          end
          oad_pkg::CLS_IMM: begin
            fmt_o <= is_misc ? oad_pkg::F_MISC : oad_pkg::F_IMM;
            op_o <= iop;
            stk_addr_o <= sp_dec[AW-1:0];
            if (is_imm) begin
              literal_o <= insn_i[oad_pkg::LIT_HI:0];
            end
          end
          oad_pkg::CLS_BIT: begin
            fmt_o <= oad_pkg::F_BIT;
            bit_op_o <= insn_i[oad_pkg::BOP_HI:oad_pkg::BOP_LO];
            // [RULE18] bit pick
            bit_mask_o <= 8'h01 << insn_i[oad_pkg::BSEL_HI:oad_pkg::BSEL_LO];
          end
          oad_pkg::CLS_JMP: begin
            fmt_o <= oad_pkg::F_JMP;
            // [RULE17] page bits on top
            target_o <= {page_select_bits, insn_i[oad_pkg::JADR_HI:0]};
          end
        endcase
      end
    end
  end

  // routing strobes, cleared when no word arrives
  always_ff @(posedge clk_i) begin
    if (rst_i || !insn_valid_i) begin
      src_mem_o <= 1'b0;
      dst_mem_o <= 1'b0;
      dst_acc_o <= 1'b0;
      dst_prodh_o <= 1'b0;
      dst_spr_o <= 1'b0;
      stk_rd_o <= 1'b0;
      stk_wr_o <= 1'b0;
      jump_o <= 1'b0;
      call_o <= 1'b0;
    end else begin
      jump_o <= is_jmp && !insn_i[oad_pkg::SUB_BIT];
      call_o <= is_jmp && insn_i[oad_pkg::SUB_BIT];
      // [RULE16] literal destination
      dst_spr_o <= is_spr;
      // [RULE8] stack byte transfer
      stk_rd_o <= is_pop;
      stk_wr_o <= is_push || is_pushl;
      // [RULE13] product routing, select ignored
      dst_prodh_o <= is_mul;
      // [RULE12] select routes result
      // [RULE14] single-operand routing
      dst_acc_o <= is_mul || (is_two && !is_stk && !is_cc && !dsel)
                   || (is_imm && !is_pushl && !is_ldh && !is_ldl && !is_spr);
      dst_mem_o <= (is_two && !is_mul && dsel)
                   || (cls == oad_pkg::CLS_BIT && !insn_i[oad_pkg::BOP_HI]);
      src_mem_o <= is_mul || (is_two && !is_mul && !dsel)
                   || (is_two && !is_stk && !is_cc)
                   || cls == oad_pkg::CLS_BIT;
    end
  end

  sequence s_two_in;
    insn_valid_i ##1 insn_valid_i;
  endsequence
  sequence s_two_out;
    dec_valid_o ##1 dec_valid_o;
  endsequence
  sequence s_push_in;
    insn_valid_i && is_push;
  endsequence
  sequence s_push_out;
    stk_wr_o && !stk_rd_o && stk_addr_o == ptr[SP][AW-1:0];
  endsequence

  AST_THRU: assert property (  // [RULE11]
    s_two_in |-> s_two_out)
    else $error("back to back words not decoded each cycle");

  AST_FMT_ONEHOT: assert property (  // [RULE19]
    dec_valid_o |-> $onehot(fmt_o))
    else $error("format code not one of five");

  AST_IND_MODE: assert property (  // [RULE1]
    insn_valid_i && insn_i[8:0] == 9'h000
    |=> mode_o == oad_pkg::M_IND
        && ea_o == $past(ptr[oad_pkg::PI_IP][AW-1:0]))
    else $error("indirect address wrong");

  AST_OFS_EA: assert property (  // [RULE5]
    insn_valid_i && insn_i[oad_pkg::FR_W-1]
    |=> ea_o == AW'($past(ofs_base) + $past({5'h00, insn_i[6:0]}))
        && mode_o == ($past(insn_i[7]) ? oad_pkg::M_SPO : oad_pkg::M_DPO))
    else $error("offset address or base pick wrong");

  AST_GLB: assert property (  // [RULE21]
    insn_valid_i && insn_i[8:7] == 2'h1
    |=> ea_o == AW'(oad_pkg::GLB_BASE + $past({5'h00, insn_i[6:0]})))
    else $error("global register address wrong");

  AST_MUL_ROUTE: assert property (  // [RULE13]
    insn_valid_i && is_mul |=> dst_acc_o && dst_prodh_o && !dst_mem_o)
    else $error("multiply routing wrong");

  AST_DSEL: assert property (  // [RULE12]
    insn_valid_i && is_two && !is_mul && !is_stk && !is_cc
    |=> dst_mem_o == $past(dsel) && dst_acc_o == !$past(dsel))
    else $error("select bit routing wrong");

  AST_CLRCMP: assert property (  // [RULE15]
    insn_valid_i && is_cc |=> op_o[0] == $past(dsel))
    else $error("select bit not part of opcode");

  AST_PUSH: assert property (  // [RULE24]
    s_push_in |=> s_push_out ##0 ptr[SP] == 16'($past(ptr[SP]) - 16'h0001))
    else $error("push did not pre-decrement stack");

  AST_POP: assert property (  // [RULE8]
    insn_valid_i && is_pop
    |=> stk_rd_o && stk_addr_o == $past(ptr[SP][AW-1:0])
        && ptr[SP] == 16'($past(ptr[SP]) + 16'h0001))
    else $error("pop did not post-increment stack");

  AST_JMP_TGT: assert property (  // [RULE17]
    insn_valid_i && is_jmp
    |=> target_o == {$past(page_select_bits), $past(insn_i[12:0])})
    else $error("jump target wrong");

  AST_BIT_MASK: assert property (  // [RULE18]
    insn_valid_i && cls == oad_pkg::CLS_BIT
    |=> $onehot(bit_mask_o) && bit_mask_o[$past(insn_i[11:9])])
    else $error("bit mask wrong");

  // bus read mux; unmapped and reserved bits read zero
  always_comb begin
    next_rdat = '0;
    for (int k = 0; k < oad_pkg::NPTR; k++) begin
      for (int h = 0; h < 2; h++) begin
        if (wb_adr_i == reg_adr(k, h)) begin
          next_rdat[7:0] = (h != 0) ? ptr[k][7:0] : ptr[k][15:8];
        end
      end
    end
    if (wb_adr_i == WB_AW'(oad_pkg::R_PAGE)) begin
      next_rdat[oad_pkg::PAGE_HI:0] = page_select_bits;
    end
    if (wb_adr_i == WB_AW'(oad_pkg::R_PRODH)) begin
      next_rdat[7:0] = product_high_register_o;
    end
    if (wb_adr_i == WB_AW'(oad_pkg::R_EA)) begin
      next_rdat[AW-1:0] = ea_o;
    end
  end

  // ack one cycle after strobe, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= next_rdat;
      end
    end
  end
endmodule // oad_decoder

/* testbench/oad_insn_model.sv */
// fetch-side model that hands instruction words to the decoder
module oad_insn_model (
  // clock
  input wire logic clk_i,
  // fetched word
  output logic insn_valid_o,
  output logic [15:0] insn_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    insn_valid_o = 1'b0;
    insn_o = 16'h0000;
  end

  task automatic send(input logic [15:0] w);
    @(posedge clk_i);
    insn_valid_o <= 1'b1;
    insn_o <= w;
    @(posedge clk_i);
    insn_valid_o <= 1'b0;
    // released word never lingers as a stale copy
    insn_o <= ~w;
    #1;
  endtask

  // two words on consecutive edges, no idle gap between them
  task automatic send_pair(input logic [15:0] w0, input logic [15:0] w1);
    @(posedge clk_i);
    insn_valid_o <= 1'b1;
    insn_o <= w0;
    @(posedge clk_i);
    insn_o <= w1;
    @(posedge clk_i);
    insn_valid_o <= 1'b0;
    insn_o <= ~w1;
    #1;
  endtask
endmodule // oad_insn_model

/* testbench/tb_oad_decoder.sv */
// self-checking bench for the operand addressing decoder
module tb_oad_decoder;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i, rst_i, cyc, stb, we, insn_valid, wr_valid, wr_carry;
  logic wr_borrow, prod_valid, dec_valid, src_mem, dst_mem, dst_acc;
  logic dst_prodh, dst_spr, stk_rd, stk_wr, jump, call, ack;
  logic [7:0] adr, wr_data, literal, bit_mask, prodh;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  logic [15:0] insn, prod, target;
  logic [11:0] wr_addr, ea, stk_addr;
  logic [4:0] fmt, mode, op;
  logic [1:0] bit_op;
  int error_cnt = 0;
  int num_checks = 0;

  oad_insn_model ins_u (.clk_i(clk_i), .insn_valid_o(insn_valid),
    .insn_o(insn));

  oad_decoder #(.WB_AW(8)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .insn_valid_i(insn_valid),
    .insn_i(insn), .wr_valid_i(wr_valid), .wr_addr_i(wr_addr),
    .wr_data_i(wr_data), .wr_carry_i(wr_carry), .wr_borrow_i(wr_borrow),
    .prod_valid_i(prod_valid), .prod_i(prod), .dec_valid_o(dec_valid),
    .fmt_o(fmt), .mode_o(mode), .ea_o(ea), .op_o(op), .src_mem_o(src_mem),
    .dst_mem_o(dst_mem), .dst_acc_o(dst_acc), .dst_prodh_o(dst_prodh),
    .dst_spr_o(dst_spr), .stk_rd_o(stk_rd), .stk_wr_o(stk_wr),
    .stk_addr_o(stk_addr), .literal_o(literal), .jump_o(jump),
    .call_o(call), .target_o(target), .bit_op_o(bit_op),
    .bit_mask_o(bit_mask), .product_high_register_o(prodh));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb_xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d, input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    dat_w <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb_xfer(1'b0, a, 8'h00, 4'hF, r);
    chk(r, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb_xfer(1'b1, a, d, 4'hF, r);
  endtask

  task automatic t_reset_unmapped();
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h40, 32'h0);
  endtask

  task automatic t_indirect();
    wr(8'h00, 8'hF3);
    wr(8'h04, 8'h85);
    ins_u.send(16'h0000);
    chk(dec_valid, 1'b1);
    chk(mode, oad_pkg::M_IND);
    chk(ea, 12'h385);
    chk({src_mem, dst_acc, dst_mem}, 3'b110);
    chk(fmt, oad_pkg::F_TWO);
  endtask

  task automatic t_data_ptr();
    ins_u.send_pair(16'h5E03, 16'h5F85);
    chk({dec_valid, op}, {1'b1, 5'h1F});
    ins_u.send(16'h0308);
    chk(mode, oad_pkg::M_DPO);
    chk(ea, 12'h38D);
    chk({dst_acc, dst_mem}, 2'b01);
  endtask

  task automatic t_stack();
    // wrap lands above the low range that pointer modes must avoid
    wr(8'h10, 8'h0F);
    wr(8'h14, 8'hFF);
    ins_u.send(16'h01FF);
    chk(mode, oad_pkg::M_SPO);
    chk(ea, 12'h07E);
    ins_u.send(16'h3883);
    chk({stk_wr, stk_rd}, 2'b10);
    chk(stk_addr, 12'hFFE);
    chk({mode, ea}, {oad_pkg::M_GLB, 12'h083});
    chk(jump | call, 1'b0);
    rd_chk(8'h14, 32'hFE);
    ins_u.send(16'h3A83);
    chk({stk_wr, stk_rd}, 2'b01);
    chk(stk_addr, 12'hFFE);
    rd_chk(8'h14, 32'hFF);
    ins_u.send(16'h5D42);
    chk({stk_wr, stk_addr, literal}, {1'b1, 12'hFFE, 8'h42});
  endtask

  task automatic t_mul_clr();
    ins_u.send(16'h3E83);
    chk({dst_prodh, dst_acc, dst_mem}, 3'b110);
    @(posedge clk_i);
    prod_valid <= 1'b1;
    prod <= 16'hAB12;
    @(posedge clk_i);
    prod_valid <= 1'b0;
    rd_chk(oad_pkg::R_PRODH, 32'hAB);
    chk(prodh, 8'hAB);
    ins_u.send(16'h3683);
    chk({src_mem, dst_mem, op}, {2'b01, 5'h1B});
    ins_u.send(16'h3483);
    chk({src_mem, dst_mem, op}, {2'b10, 5'h1A});
    ins_u.send(16'h0283);
    chk({src_mem, dst_mem, dst_acc}, 3'b110);
  endtask

  task automatic t_formats();
    ins_u.send(16'h405A);
    chk({fmt, literal, dst_acc}, {oad_pkg::F_IMM, 8'h5A, 1'b1});
    ins_u.send(16'h5C11);
    chk({dst_spr, literal}, {1'b1, 8'h11});
    ins_u.send(16'h6105);
    chk(fmt, oad_pkg::F_MISC);
    ins_u.send(16'hF234);
    chk({fmt, call}, {oad_pkg::F_JMP, 1'b1});
    chk(target, 16'hB234);
    ins_u.send(16'h8A83);
    chk({fmt, bit_op, bit_mask}, {oad_pkg::F_BIT, 2'h0, 8'h20});
  endtask

  // core writeback of the data pointer low byte
  task automatic core_wr(input logic [7:0] d, input logic cy, input logic bw);
    @(posedge clk_i);
    wr_valid <= 1'b1;
    wr_addr <= 12'h007;
    wr_data <= d;
    wr_carry <= cy;
    wr_borrow <= bw;
    @(posedge clk_i);
    wr_valid <= 1'b0;
    wr_carry <= 1'b0;
    wr_borrow <= 1'b0;
  endtask

  task automatic t_carry();
    logic [31:0] r;
    core_wr(8'h00, 1'b1, 1'b0);
    rd_chk(8'h08, 32'h04);
    rd_chk(8'h0C, 32'h00);
    core_wr(8'hFF, 1'b0, 1'b1);
    rd_chk(8'h08, 32'h03);
    rd_chk(8'h0C, 32'hFF);
    // low byte lane off, so the write must be dropped
    wb_xfer(1'b1, 8'h08, 8'h55, 4'hE, r);
    rd_chk(8'h08, 32'h03);
  endtask

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, wr_valid, wr_carry, wr_borrow, prod_valid} = 7'h00;
    adr = 8'h00;
    sel = 4'hF;
    dat_w = 32'h0;
    wr_addr = 12'h000;
    wr_data = 8'h00;
    prod = 16'h0000;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_unmapped();
    t_indirect();
    t_data_ptr();
    t_stack();
    t_mul_clr();
    t_formats();
    t_carry();
    tally_and_finish();
  end

  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // tb_oad_decoder
